/* bench/clock_output_freeze_control_chk.sv */
// Port assertions for the clock output freeze control block
`timescale 1ns/100ps
module clock_output_freeze_control_chk
  import freeze_ctrl_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             common_freeze_n_i,
  input wire logic             freeze_strobe_n_i,
  input wire logic             legacy_cpu_clock_mode_i,
  input wire logic             double_rate_cpu_clock_o,
  input wire logic             cpu_clock_qualifier_o,
  input wire logic             first_bus_clock_out_o,
  input wire logic [OUT_N-1:0] output_enabled_o
);
  logic [3:0] run_q;
  // Period checks only once the qualifier has run long enough to refill its pipe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 4'h0;
    end else if (!output_enabled_o[IDX_CPUQ]) begin
      run_q <= 4'h0;
    end else if (run_q != 4'hf) begin
      run_q <= run_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_cpuq_period;
    run_q == 4'hf && $rose(cpu_clock_qualifier_o)
      |-> $past(cpu_clock_qualifier_o, 3) && !$past(cpu_clock_qualifier_o, 2);
  endproperty
  a_cpuq_period: assert property (p_cpuq_period) else $error("qualifier period");
  property p_dbl_legacy;
    (legacy_cpu_clock_mode_i && output_enabled_o[IDX_DBL]) [*8] ##0
      (run_q == 4'hf && $rose(double_rate_cpu_clock_o)) |-> $past(double_rate_cpu_clock_o, 2);
  endproperty
  a_dbl_legacy: assert property (p_dbl_legacy) else $error("double rate period");
  property p_cpuq_high;
    $rose(cpu_clock_qualifier_o) |=> cpu_clock_qualifier_o;
  endproperty
  a_cpuq_high: assert property (p_cpuq_high) else $error("short qualifier pulse");
  property p_bus_first_high;
    $rose(first_bus_clock_out_o) |=> first_bus_clock_out_o;
  endproperty
  a_bus_first_high: assert property (p_bus_first_high) else $error("short bus pulse");
  property p_cpuq_frozen;
    !output_enabled_o[IDX_CPUQ] [*8] |-> !cpu_clock_qualifier_o;
  endproperty
  a_cpuq_frozen: assert property (p_cpuq_frozen) else $error("frozen output runs");
  property p_first_by_strobe;
    $changed(output_enabled_o[IDX_EXP_FIRST:IDX_BUS_FIRST]) |-> !$past(freeze_strobe_n_i, 3)
      || !$past(freeze_strobe_n_i, 4) || !$past(freeze_strobe_n_i, 5);
  endproperty
  a_first_by_strobe: assert property (p_first_by_strobe) else $error("unmasked changed");
  property p_all_equal;
    $changed(output_enabled_o[IDX_EXP_FIRST:IDX_BUS_FIRST])
      |-> output_enabled_o == RUN_ALL || output_enabled_o == FREEZE_ALL;
  endproperty
  a_all_equal: assert property (p_all_equal) else $error("strobe split outputs");
  property p_strobe_run;
    $past(common_freeze_n_i, 3) && common_freeze_n_i && $fell(freeze_strobe_n_i)
      |-> ##[2:5] output_enabled_o == RUN_ALL;
  endproperty
  a_strobe_run: assert property (p_strobe_run) else $error("strobe run missed");
  property p_strobe_freeze;
    !$past(common_freeze_n_i, 3) && !common_freeze_n_i && $fell(freeze_strobe_n_i)
      |-> ##[2:5] output_enabled_o == FREEZE_ALL;
  endproperty
  a_strobe_freeze: assert property (p_strobe_freeze) else $error("strobe freeze missed");
  c_freeze: cover property ($changed(output_enabled_o) && output_enabled_o == FREEZE_ALL);
  c_serial: cover property ($changed(output_enabled_o[MASK_W-1:0]) && output_enabled_o[13]);
  c_legacy: cover property (legacy_cpu_clock_mode_i && $rose(double_rate_cpu_clock_o));
endmodule : clock_output_freeze_control_chk

bind clock_output_freeze_control clock_output_freeze_control_chk i_clock_output_freeze_control_chk (
  .clk_i                   (clk_i),
  .rst_i                   (rst_i),
  .common_freeze_n_i       (common_freeze_n_i),
  .freeze_strobe_n_i       (freeze_strobe_n_i),
  .legacy_cpu_clock_mode_i (legacy_cpu_clock_mode_i),
  .double_rate_cpu_clock_o (double_rate_cpu_clock_o),
  .cpu_clock_qualifier_o   (cpu_clock_qualifier_o),
  .first_bus_clock_out_o   (first_bus_clock_out_o),
  .output_enabled_o        (output_enabled_o)
);

/* bench/clock_output_freeze_control_tb.sv */
// Self-checking testbench for the clock output freeze control block
`timescale 1ns/100ps
`define CHECK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin \
  num_errors++; $display("Error at %0t: %s", $time, msg); end end
module clock_output_freeze_control_tb
  import freeze_ctrl_pkg::*;
;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             serial_clk = 1'b0;
  logic             serial_data;
  logic             common_freeze_n = 1'b1;
  logic             freeze_strobe_n = 1'b1;
  logic             legacy_mode = 1'b1;
  logic [1:0]       bus_ratio = 2'h0;
  logic [1:0]       exp_ratio = 2'h0;
  logic             dbl, cpuq, busq, bus_first, exp_first;
  logic [BUS_N-1:0] bus_clk;
  logic [EXP_N-1:0] exp_clk;
  logic [OUT_N-1:0] enabled;
  logic [OUT_N-1:0] outs;
  int               num_errors = 0;
  int               cmp_count = 0;

  always #10 clk_i = ~clk_i;
  // Offset start keeps the serial clock out of phase with the base clock
  initial #3 forever #6 serial_clk = ~serial_clk;
  assign outs = {exp_first, bus_first, exp_clk, bus_clk, busq, cpuq, dbl};

  clock_output_freeze_control i_clock_output_freeze_control (
    .clk_i(clk_i), .rst_i(rst_i), .freeze_serial_clk_i(serial_clk),
    .freeze_serial_data_i(serial_data), .common_freeze_n_i(common_freeze_n),
    .freeze_strobe_n_i(freeze_strobe_n), .legacy_cpu_clock_mode_i(legacy_mode),
    .bus_ratio_i(bus_ratio), .expansion_ratio_i(exp_ratio),
    .double_rate_cpu_clock_o(dbl), .cpu_clock_qualifier_o(cpuq),
    .bus_clock_qualifier_o(busq), .first_bus_clock_out_o(bus_first),
    .bus_clock_o(bus_clk), .first_expansion_clock_out_o(exp_first),
    .expansion_clock_o(exp_clk), .output_enabled_o(enabled));
  freeze_serial_ctrl i_freeze_serial_ctrl (
    .serial_clk_i(serial_clk), .serial_data_o(serial_data));

  task automatic seen_high(output logic [OUT_N-1:0] s);
    s = '0;
    repeat (40) begin
      @(negedge clk_i);
      s = s | outs;
    end
  endtask : seen_high

  task automatic meas(input int idx, output int hi, output int lo);
    hi = 0;
    lo = 0;
    for (int i = 0; i < 40 && outs[idx] !== 1'b0; i++) @(negedge clk_i);
    for (int i = 0; i < 40 && outs[idx] !== 1'b1; i++) @(negedge clk_i);
    while (outs[idx] === 1'b1 && hi < 40) begin hi++; @(negedge clk_i); end
    while (outs[idx] === 1'b0 && lo < 40) begin lo++; @(negedge clk_i); end
  endtask : meas

  task automatic strobe(input logic level);
    @(posedge clk_i);
    common_freeze_n <= level;
    repeat (4) @(posedge clk_i);
    freeze_strobe_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    freeze_strobe_n <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask : strobe

  task automatic test_serial;
    logic [MASK_W-1:0] masks [3] = '{13'h1555, 13'h0aaa, 13'h0000};
    logic [OUT_N-1:0]  prev = RUN_ALL;
    logic [OUT_N-1:0]  s;
    foreach (masks[k]) begin
      fork
        i_freeze_serial_ctrl.send_mask(masks[k], k);
        begin
          repeat (6 + k) @(posedge clk_i);
          `CHECK(enabled, prev, "mask applied mid frame")
        end
      join
      repeat (12) @(posedge clk_i);
      prev = {2'b11, masks[k]};
      `CHECK(enabled, prev, "mask not applied")
      seen_high(s);
      `CHECK(s, prev, "outputs against mask")
    end
    $display("Test serial done at %0t", $time);
  endtask : test_serial

  task automatic test_strobe;
    logic [OUT_N-1:0] s;
    strobe(1'b0);
    `CHECK(enabled, FREEZE_ALL, "strobe freeze")
    seen_high(s);
    `CHECK(s, FREEZE_ALL, "outputs not frozen")
    strobe(1'b1);
    `CHECK(enabled, RUN_ALL, "strobe run")
    seen_high(s);
    `CHECK(s, RUN_ALL, "outputs not running")
    $display("Test strobe done at %0t", $time);
  endtask : test_strobe

  task automatic test_ratios;
    int hi;
    int lo;
    int pos [8] = '{0, 1, 2, 3, 4, 5, 6, 13};
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_i);
      bus_ratio <= r[1:0];
      exp_ratio <= r[1:0];
      repeat (40) @(posedge clk_i);
      meas(IDX_BUSQ, hi, lo);
      `CHECK(hi, (r == 0) ? 2 : 4 * r, "bus qualifier high")
      `CHECK(lo, (r == 0) ? 2 : 4, "bus qualifier low")
      meas(IDX_BUS_LO, hi, lo);
      `CHECK(hi + lo, 4 * (r + 1), "bus clock period")
      meas(IDX_EXP_LO, hi, lo);
      `CHECK(hi + lo, 4 * (r + 1), "expansion clock period")
    end
    meas(IDX_DBL, hi, lo);
    `CHECK(hi + lo, 2, "double rate period")
    meas(IDX_CPUQ, hi, lo);
    `CHECK(hi + lo, 4, "qualifier period")
    @(posedge clk_i);
    legacy_mode <= 1'b0;
    bus_ratio <= 2'h0;
    repeat (40) @(posedge clk_i);
    foreach (pos[k]) begin
      meas(pos[k], hi, lo);
      `CHECK(hi + lo, 4, "bus speed period")
    end
    $display("Test ratios done at %0t", $time);
  endtask : test_ratios

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // The whole sequence needs under a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    test_serial();
    test_strobe();
    test_ratios();
    stop_test();
  end
endmodule : clock_output_freeze_control_tb

/* bench/freeze_serial_ctrl.sv */
// Controller model that drives the serial freeze mask port
`timescale 1ns/100ps
module freeze_serial_ctrl
  import freeze_ctrl_pkg::*;
(
  input  wire logic serial_clk_i,
  output logic      serial_data_o
);
  initial serial_data_o = 1'b1;

  // Gap sets idle bits before the start bit, to answer slowly or promptly
  task automatic send_mask(input logic [MASK_W-1:0] mask, input int gap);
    repeat (gap + 1) @(posedge serial_clk_i);
    serial_data_o <= START_LEVEL;
    for (int i = 0; i < MASK_W; i++) begin
      @(posedge serial_clk_i);
      serial_data_o <= mask[i];
    end
    @(posedge serial_clk_i);
    serial_data_o <= 1'b1;
  endtask : send_mask
endmodule : freeze_serial_ctrl

/* logic/clock_gate_cell.sv */
// Runt-free gate for one clock output
`timescale 1ns/100ps
module clock_gate_cell
  import freeze_ctrl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  input  wire logic want_i,
  output logic      clk_o
);

  typedef struct packed {
    logic en;
    logic out;
  } gate_state_t;

  gate_state_t s_q;
  gate_state_t s_d;

  always_comb begin
    s_d = s_q;
    // Enable only moves while the raw clock is low, so edges are never cut short
    if (!raw_i) begin
      s_d.en = want_i;
    end
    s_d.out = raw_i & s_d.en;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{en: 1'b1, out: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_o = s_q.out;

endmodule : clock_gate_cell

/* logic/clock_output_freeze_control.sv */
// Clock output generation with serial and common freeze control
// What this block does
// - Hold a 13-bit serial mask, one enable bit for 13 of 15 outputs.
// - First bus clock and first expansion clock ignore the serial mask.
// - Mask bit 0 freezes its output low; mask bit 1 lets it run.
// - Strobe low pulse with common level low freezes all 15 outputs.
// - Strobe low pulse with common level high unfreezes all 15 outputs.
// - A frozen output is held low only after its natural falling edge.
// - An unfrozen output restarts only while it would be low, no runt pulse.
// - One bit per serial clock period, sampled on the rising edge.
// - Bit 0 double rate, 1 cpu qual, 2 bus qual, 3-6 bus, 7-12 expansion.
// - In legacy mode the processor clock qualifier runs at half the double-rate clock.
// - In legacy mode the bus clock qualifier runs at 1, 1/2, 1/3 or 1/4 of processor clock.
// - At 1/3 and 1/4 the bus qualifier duty is 66/33 and 75/25.
// - Outside legacy mode at bus ratio 1x eight outputs run at bus speed, seven expansion.
`timescale 1ns/100ps
module clock_output_freeze_control
  import freeze_ctrl_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             freeze_serial_clk_i,
  input  wire logic             freeze_serial_data_i,
  input  wire logic             common_freeze_n_i,
  input  wire logic             freeze_strobe_n_i,
  input  wire logic             legacy_cpu_clock_mode_i,
  input  wire logic [1:0]       bus_ratio_i,
  input  wire logic [1:0]       expansion_ratio_i,
  output logic                  double_rate_cpu_clock_o,
  output logic                  cpu_clock_qualifier_o,
  output logic                  bus_clock_qualifier_o,
  output logic                  first_bus_clock_out_o,
  output logic [BUS_N-1:0]      bus_clock_o,
  output logic                  first_expansion_clock_out_o,
  output logic [EXP_N-1:0]      expansion_clock_o,
  output logic [OUT_N-1:0]      output_enabled_o
);

  // Length of one processor period in divided units, and the first index
  localparam logic [2:0] LEN_ONE  = 3'h1;
  localparam logic [1:0] IDX_ZERO = 2'h0;

  // Ratio code to divide length in processor clock periods
  function automatic logic [2:0] ratio_len(input logic [1:0] code);
    ratio_len = {1'b0, code} + LEN_ONE;
  endfunction : ratio_len

  // Position in base cycles inside one divided period
  function automatic logic [4:0] period_pos(input logic [1:0] idx,
                                            input logic [1:0] phase);
    period_pos = {1'b0, idx, 2'h0} + {3'h0, phase};
  endfunction : period_pos

  // Square wave of len processor periods, high for the first half
  function automatic logic half_duty_high(input logic [1:0] idx,
                                          input logic [1:0] phase,
                                          input logic [1:0] code);
    logic [4:0] half;
    half           = {2'h0, ratio_len(code)} * (PHASES >> 1);
    half_duty_high = period_pos(idx, phase) < half;
  endfunction : half_duty_high

  // Divided index wraps at len-1; the ratio it is stepped with only changes at a wrap
  function automatic logic [1:0] next_idx(input logic [1:0] idx,
                                          input logic [1:0] code);
    logic [2:0] nxt;
    nxt = {1'b0, idx} + 3'h1;
    if (nxt >= ratio_len(code)) begin
      next_idx = 2'h0;
    end else begin
      next_idx = nxt[1:0];
    end
  endfunction : next_idx

  // Steps a divided index at the end of a processor period; a new ratio
  // is only taken at a wrap, so a ratio change never cuts a pulse short
  function automatic logic [3:0] advance(input logic [1:0] idx,
                                         input logic [1:0] code_used,
                                         input logic [1:0] code_pin);
    logic [1:0] nxt;
    nxt = next_idx(idx, code_used);
    if (nxt == IDX_ZERO) begin
      advance = {code_pin, nxt};
    end else begin
      advance = {code_used, nxt};
    end
  endfunction : advance

  // Legacy bus qualifier: high for all but the last processor period of
  // the divided period, giving 50/50, 66/33 and 75/25 at 1/2, 1/3 and 1/4
  function automatic logic qual_high(input logic [1:0] idx,
                                     input logic [2:0] len,
                                     input logic       cpu);
    if (len == LEN_ONE) begin
      qual_high = cpu;
    end else begin
      qual_high = ({1'b0, idx} < (len - LEN_ONE));
    end
  endfunction : qual_high

  // Double rate clock toggles every base cycle in legacy mode and
  // follows the processor clock otherwise
  function automatic logic dbl_wave(input logic       legacy,
                                    input logic [1:0] phase,
                                    input logic       cpu);
    if (legacy) begin
      dbl_wave = ~phase[0];
    end else begin
      dbl_wave = cpu;
    end
  endfunction : dbl_wave

  // Fans the five wave shapes out onto the fifteen output positions
  function automatic logic [OUT_N-1:0] spread_raw(input logic dbl,
                                                  input logic cpu,
                                                  input logic busq,
                                                  input logic bus,
                                                  input logic expn);
    spread_raw                = FREEZE_ALL;
    spread_raw[IDX_DBL]       = dbl;
    spread_raw[IDX_CPUQ]      = cpu;
    spread_raw[IDX_BUSQ]      = busq;
    spread_raw[IDX_BUS_FIRST] = bus;
    spread_raw[IDX_EXP_FIRST] = expn;
    // One wave per group keeps every clock of a group in phase
    for (int i = 0; i < BUS_N; i++) begin
      spread_raw[IDX_BUS_LO + i] = bus;
    end
    for (int i = 0; i < EXP_N; i++) begin
      spread_raw[IDX_EXP_LO + i] = expn;
    end
  endfunction : spread_raw

  // Next run request: a finished serial word rewrites the masked
  // positions, then a strobe edge overrides every position
  function automatic logic [OUT_N-1:0] next_want(input logic [OUT_N-1:0]  want,
                                                 input logic              load,
                                                 input logic [MASK_W-1:0] mask,
                                                 input logic              fall,
                                                 input logic              level);
    next_want = want;
    if (load) begin
      // The two positions above the mask width are never touched here
      next_want[MASK_W-1:0] = mask;
    end
    // Strobe last, so it overrides a serial load in the same cycle
    if (fall) begin
      if (level) begin
        next_want = RUN_ALL;
      end else begin
        next_want = FREEZE_ALL;
      end
    end
  endfunction : next_want

  typedef struct packed {
    logic                 mode_s1;
    logic                 mode_s2;
    logic [1:0]           bus_ratio_s1;
    logic [1:0]           bus_ratio_s2;
    logic [1:0]           exp_ratio_s1;
    logic [1:0]           exp_ratio_s2;
    logic                 level_s1;
    logic                 level_s2;
    logic                 strobe_s1;
    logic                 strobe_s2;
    logic                 strobe_old;
    logic                 req_s1;
    logic                 req_s2;
    logic                 ack;
    logic [1:0]           phase;
    logic [1:0]           bus_idx;
    logic [1:0]           exp_idx;
    logic [1:0]           bus_code;
    logic [1:0]           exp_code;
    logic [OUT_N-1:0]     raw;
    logic [OUT_N-1:0]     want;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{
    mode_s1:      1'b1,
    mode_s2:      1'b1,
    bus_ratio_s1: RATIO_1X,
    bus_ratio_s2: RATIO_1X,
    exp_ratio_s1: RATIO_1X,
    exp_ratio_s2: RATIO_1X,
    level_s1:     1'b1,
    level_s2:     1'b1,
    strobe_s1:    1'b1,
    strobe_s2:    1'b1,
    strobe_old:   1'b1,
    req_s1:       1'b0,
    req_s2:       1'b0,
    ack:          1'b0,
    phase:        2'h0,
    bus_idx:      2'h0,
    exp_idx:      2'h0,
    bus_code:     RATIO_1X,
    exp_code:     RATIO_1X,
    raw:          FREEZE_ALL,
    want:         RUN_ALL
  };

  ctrl_t             s_q;
  ctrl_t             s_d;
  logic [MASK_W-1:0] rx_mask;
  logic              rx_req;
  logic [OUT_N-1:0]  gated;

  // Serial port lives on its own free-running clock
  freeze_mask_receiver u_rx (
    .serial_clk_i  (freeze_serial_clk_i),
    .rst_i         (rst_i),
    .serial_data_i (freeze_serial_data_i),
    .ack_tgl_i     (s_q.ack),
    .mask_o        (rx_mask),
    .req_tgl_o     (rx_req)
  );

  always_comb begin
    logic       legacy;
    logic       strobe_fall;
    logic       mask_new;
    logic       cpu_high;
    logic       dbl_high;
    logic       busq_high;
    logic       bus_high;
    logic       exp_high;
    logic [1:0] bus_code;
    logic [1:0] exp_code;
    logic [2:0] bus_len;
    legacy      = 1'b0;
    strobe_fall = 1'b0;
    mask_new    = 1'b0;
    cpu_high    = 1'b0;
    dbl_high    = 1'b0;
    busq_high   = 1'b0;
    bus_high    = 1'b0;
    exp_high    = 1'b0;
    bus_code    = RATIO_1X;
    exp_code    = RATIO_1X;
    bus_len     = LEN_ONE;
    s_d         = s_q;

    // Pin synchronisers; the first stage is never looked at, and the strobe edge also uses strobe_old
    s_d.mode_s1      = legacy_cpu_clock_mode_i;
    s_d.mode_s2      = s_q.mode_s1;
    s_d.bus_ratio_s1 = bus_ratio_i;
    s_d.bus_ratio_s2 = s_q.bus_ratio_s1;
    s_d.exp_ratio_s1 = expansion_ratio_i;
    s_d.exp_ratio_s2 = s_q.exp_ratio_s1;
    s_d.level_s1     = common_freeze_n_i;
    s_d.level_s2     = s_q.level_s1;
    s_d.strobe_s1    = freeze_strobe_n_i;
    s_d.strobe_s2    = s_q.strobe_s1;
    s_d.strobe_old   = s_q.strobe_s2;
    s_d.req_s1       = rx_req;
    s_d.req_s2       = s_q.req_s1;

    // Synchronised pins; the ratio in use changes only at a period wrap
    legacy   = s_q.mode_s2;
    bus_code = s_q.bus_ratio_s2;
    exp_code = s_q.exp_ratio_s2;
    bus_len  = ratio_len(s_q.bus_code);

    // Free-running dividers; freezing never stops them, so a thawed
    // output comes back in phase with the ones that kept running
    s_d.phase = s_q.phase + 2'h1;
    if (s_q.phase == PHASE_LAST) begin
      // Pin ratios wait for the end of the divided period in use
      {s_d.bus_code, s_d.bus_idx} = advance(s_q.bus_idx, s_q.bus_code, bus_code);
      {s_d.exp_code, s_d.exp_idx} = advance(s_q.exp_idx, s_q.exp_code, exp_code);
    end

    // Processor clock: one period per four base cycles
    cpu_high = s_q.phase < HALF_PHASE;
    // Double rate clock: twice the processor clock only in legacy mode
    dbl_high = dbl_wave(legacy, s_q.phase, cpu_high);

    // Outside legacy mode the bus qualifier runs at processor speed
    if (!legacy) begin
      busq_high = cpu_high;
    end else begin
      busq_high = qual_high(s_q.bus_idx, bus_len, cpu_high);
    end

    // Bus and expansion clocks: square waves of the divided period
    bus_high = half_duty_high(s_q.bus_idx, s_q.phase, s_q.bus_code);
    exp_high = half_duty_high(s_q.exp_idx, s_q.phase, s_q.exp_code);

    // The processor qualifier is the divide-by-four wave itself
    s_d.raw = spread_raw(dbl_high, cpu_high, busq_high, bus_high, exp_high);

    // Completed serial word: request toggle differs from our ack
    mask_new = s_q.req_s2 != s_q.ack;
    if (mask_new) begin
      // Mask word is stable until the ack returns to the serial side
      s_d.ack = s_q.req_s2;
    end

    // The mask word is read only while a hand-over is open, when it cannot move;
    // the common strobe reaches every output and wins over a serial load
    strobe_fall = s_q.strobe_old & ~s_q.strobe_s2;
    s_d.want    = next_want(s_q.want, mask_new, rx_mask, strobe_fall, s_q.level_s2);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // One runt-free gate per output; a 1 in want lets it run
  for (genvar g = 0; g < OUT_N; g++) begin : g_gate
    clock_gate_cell u_gate (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .raw_i  (s_q.raw[g]),
      .want_i (s_q.want[g]),
      .clk_o  (gated[g])
    );
  end

  // Output order follows the mask bit order
  assign double_rate_cpu_clock_o     = gated[IDX_DBL];
  assign cpu_clock_qualifier_o       = gated[IDX_CPUQ];
  assign bus_clock_qualifier_o       = gated[IDX_BUSQ];
  assign bus_clock_o                 = gated[IDX_BUS_LO +: BUS_N];
  assign expansion_clock_o           = gated[IDX_EXP_LO +: EXP_N];
  assign first_bus_clock_out_o       = gated[IDX_BUS_FIRST];
  assign first_expansion_clock_out_o = gated[IDX_EXP_FIRST];
  assign output_enabled_o            = s_q.want;

endmodule : clock_output_freeze_control

/* logic/freeze_mask_receiver.sv */
// Serial freeze mask receiver on the serial port clock
`timescale 1ns/100ps
module freeze_mask_receiver
  import freeze_ctrl_pkg::*;
(
  input  wire logic              serial_clk_i,
  input  wire logic              rst_i,
  input  wire logic              serial_data_i,
  input  wire logic              ack_tgl_i,
  output logic [MASK_W-1:0]      mask_o,
  output logic                   req_tgl_o
);

  typedef struct packed {
    rx_state_t              st;
    logic [BIT_CNT_W-1:0]   cnt;
    logic [MASK_W-1:0]      shift;
    logic [MASK_W-1:0]      word;
    logic                   req;
    logic                   ack_s1;
    logic                   ack_s2;
  } rx_t;

  rx_t s_q;
  rx_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.ack_s1 = ack_tgl_i;
    s_d.ack_s2 = s_q.ack_s1;
    case (s_q.st)
      RX_IDLE: begin
        // Line idles high; a low bit on a rising edge starts a frame
        if (serial_data_i == START_LEVEL) begin
          s_d.st  = RX_SHIFT;
          s_d.cnt = '0;
        end
      end
      RX_SHIFT: begin
        // First bit after the start bit lands in bit 0
        s_d.shift = {serial_data_i, s_q.shift[MASK_W-1:1]};
        if (s_q.cnt == LAST_BIT) begin
          s_d.st = RX_IDLE;
          // Word is handed over only once complete; a frame that ends while
          // the previous hand-over is still open is dropped
          if (s_q.ack_s2 == s_q.req) begin
            s_d.word = s_d.shift;
            s_d.req  = ~s_q.req;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: begin
        s_d.st = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge serial_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{st: RX_IDLE, cnt: '0, shift: MASK_RESET, word: MASK_RESET,
               req: 1'b0, ack_s1: 1'b0, ack_s2: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign mask_o    = s_q.word;
  assign req_tgl_o = s_q.req;

endmodule : freeze_mask_receiver

/* shared/freeze_ctrl_pkg.sv */
// Shared constants and types for the clock output freeze control block
package freeze_ctrl_pkg;

  // Serial mask layout
  localparam int          MASK_W      = 13;
  localparam int          OUT_N       = 15;
  localparam int          BIT_CNT_W   = 4;
  localparam logic [3:0]  LAST_BIT    = 4'hc;
  localparam logic        START_LEVEL = 1'b0;
  localparam logic [12:0] MASK_RESET  = 13'h1fff;

  // Whole-output enable patterns
  localparam logic [14:0] RUN_ALL     = 15'h7fff;
  localparam logic [14:0] FREEZE_ALL  = 15'h0000;

  // Output positions; mask bits 0 to 12 map onto positions 0 to 12
  localparam int IDX_DBL       = 0;
  localparam int IDX_CPUQ      = 1;
  localparam int IDX_BUSQ      = 2;
  localparam int IDX_BUS_LO    = 3;
  localparam int BUS_N         = 4;
  localparam int IDX_EXP_LO    = 7;
  localparam int EXP_N         = 6;
  localparam int IDX_BUS_FIRST = 13;
  localparam int IDX_EXP_FIRST = 14;

  // Processor clock period is four base clock cycles
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] HALF_PHASE = 2'h2;
  localparam logic [4:0] PHASES     = 5'h04;

  // Ratio pin codes: 0 = 1x, 1 = 1/2x, 2 = 1/3x, 3 = 1/4x of the processor clock
  localparam logic [1:0] RATIO_1X   = 2'h0;

  // Serial receiver states
  typedef enum logic {
    RX_IDLE,
    RX_SHIFT
  } rx_state_t;

endpackage : freeze_ctrl_pkg
